// *** design/rcl_pkg.sv ***
// Constants, types and register map of the reset cause and init logic
package rcl_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned EXT_CLEAR_MIN_NS = 2000;
  localparam int unsigned EXT_CLEAR_CYC =
    (EXT_CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets
  localparam logic [8:0] ADDR_STATUS = 9'h003;
  localparam logic [8:0] ADDR_PORT = 9'h005;
  localparam logic [8:0] ADDR_IRQ_CTRL = 9'h00B;
  localparam logic [8:0] ADDR_PIR = 9'h00C;
  localparam logic [8:0] ADDR_PWR = 9'h08E;
  localparam logic [8:0] ADDR_ANALOG = 9'h091;
  localparam logic [8:0] ADDR_NV_DATA = 9'h09A;
  localparam logic [8:0] ADDR_NV_ADDR = 9'h09B;
  localparam logic [8:0] ADDR_NV_CTRL = 9'h09C;

  // Field positions
  localparam int unsigned STATUS_TO_BIT = 4;
  localparam int unsigned STATUS_PD_BIT = 3;
  localparam int unsigned PWR_EN_BIT = 2;
  localparam int unsigned PWR_POR_BIT = 1;
  localparam int unsigned PWR_DIP_BIT = 0;
  localparam int unsigned NV_ABORT_BIT = 3;
  localparam int unsigned GIE_BIT = 7;

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [2:0] PWR_RST = 3'h4;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] PIR_RST = 8'h00;
  localparam logic [7:0] ANALOG_RST = 8'hFF;
  localparam logic [7:0] NV_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [12:0] PC_VECTOR = 13'h0004;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'b000,
    CAUSE_WDT_RUN = 3'b001,
    CAUSE_WDT_WAKE = 3'b010,
    CAUSE_PIN_RUN = 3'b011,
    CAUSE_PIN_SLEEP = 3'b100,
    CAUSE_SUPPLY_DIP = 3'b101,
    CAUSE_IRQ_WAKE = 3'b110
  } rcl_cause_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } rcl_req_type;

endpackage

// *** design/rcl_reset_logic.sv ***
// Reset cause classification and register initialisation
`timescale 1ns/100ps
module rcl_reset_logic (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  // Reset and wake sources
  input wire logic external_clear_pin_b,
  input wire logic watchdog_timer_expired,
  input wire logic power_on_detect,
  input wire logic supply_dip_detect,
  input wire logic [7:0] wake_irq_flags,
  // Core handshakes
  input wire logic sleep_enter,
  input wire logic instr_step,
  input wire logic nv_write_busy,
  input wire logic nv_write_done,
  // Register port
  input wire rcl_pkg::rcl_req_type reg_req,
  output logic [7:0] reg_rdata,
  // Core state
  output logic core_reset,
  output logic [12:0] program_counter,
  output logic sleeping,
  output logic wake_pulse,
  output rcl_pkg::rcl_cause_type last_cause,
  output logic [7:0] irq_control_reg,
  output logic [7:0] port_latch,
  output logic [7:0] nv_data_reg,
  output logic [7:0] nv_addr_reg
);

  function automatic logic hit(input logic [8:0] a, input logic [8:0] t);
    hit = (a == t);
  endfunction

  logic [7:0] filt_cnt_q, filt_cnt_d;
  logic rst_q, rst_d;
  logic sleeping_q, sleeping_d;
  logic vec_pend_q, vec_pend_d;
  logic wake_q, wake_d;
  logic [12:0] pc_q, pc_d;
  rcl_pkg::rcl_cause_type cause_q, cause_d;
  logic [7:0] status_q, status_d;
  logic [2:0] pwr_q, pwr_d;
  logic [7:0] irq_ctrl_q, irq_ctrl_d;
  logic [7:0] pir_q, pir_d;
  logic [7:0] analog_q, analog_d;
  logic [7:0] nv_data_q, nv_data_d;
  logic [7:0] nv_addr_q, nv_addr_d;
  logic abort_q, abort_d;
  logic [7:0] port_q, port_d;
  logic [7:0] rdata_q, rdata_d;
  logic pin_hit;
  logic wdt_reset;
  logic any_src;
  logic entry;
  logic wdt_wake;
  logic irq_wake;
  logic wr_ok;

  localparam logic [7:0] FILT_MAX = 8'(rcl_pkg::EXT_CLEAR_CYC);

  always_comb begin
    // Glitch filter: count low cycles, restart on any high sample
    filt_cnt_d = filt_cnt_q;
    if (external_clear_pin_b) begin
      filt_cnt_d = 8'h00;
    end else if (filt_cnt_q != FILT_MAX) begin
      filt_cnt_d = filt_cnt_q + 8'h01;
    end
    // Gated by the live pin so reset drops the edge after the pin rises
    pin_hit = ~external_clear_pin_b & (filt_cnt_q == FILT_MAX);

    // A watchdog expiry only resets while running
    wdt_reset = watchdog_timer_expired & ~sleeping_q;
    any_src = power_on_detect | supply_dip_detect | pin_hit
              | wdt_reset;
    entry = any_src & ~rst_q;
    wdt_wake = watchdog_timer_expired & sleeping_q & ~any_src;
    irq_wake = (|wake_irq_flags) & sleeping_q & ~any_src & ~wdt_wake;
    rst_d = any_src;
    wr_ok = reg_req.wr & ~rst_q;

    sleeping_d = sleeping_q;
    vec_pend_d = vec_pend_q;
    wake_d = wdt_wake | irq_wake;
    pc_d = pc_q;
    cause_d = cause_q;
    status_d = status_q;
    pwr_d = pwr_q;
    irq_ctrl_d = irq_ctrl_q;
    pir_d = pir_q;
    analog_d = analog_q;
    nv_data_d = nv_data_q;
    nv_addr_d = nv_addr_q;
    abort_d = abort_q;
    port_d = port_q;

    // Software writes
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_STATUS)) begin
      status_d[7:5] = reg_req.wdata[7:5];
      status_d[2:0] = reg_req.wdata[2:0];
    end
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_PWR)) begin
      pwr_d = reg_req.wdata[2:0];
    end
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_IRQ_CTRL)) begin
      irq_ctrl_d = reg_req.wdata;
    end
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_PIR)) begin
      pir_d = reg_req.wdata;
    end
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_ANALOG)) begin
      analog_d = reg_req.wdata;
    end
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_NV_DATA)) begin
      nv_data_d = reg_req.wdata;
    end
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_NV_ADDR)) begin
      nv_addr_d = reg_req.wdata;
    end
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_PORT)) begin
      port_d = reg_req.wdata;
    end
    if (nv_write_done) begin
      abort_d = 1'b0;
    end
    if (wr_ok && hit(reg_req.addr, rcl_pkg::ADDR_NV_CTRL)) begin
      abort_d = reg_req.wdata[rcl_pkg::NV_ABORT_BIT];
    end

    // Core stepping and sleep entry
    if (!sleeping_q && !rst_q && instr_step) begin
      if (vec_pend_q) begin
        pc_d = rcl_pkg::PC_VECTOR;
        vec_pend_d = 1'b0;
      end else begin
        pc_d = pc_q + 13'h0001;
      end
    end
    if (!sleeping_q && !rst_q && sleep_enter) begin
      sleeping_d = 1'b1;
      status_d[rcl_pkg::STATUS_TO_BIT] = 1'b1;
      status_d[rcl_pkg::STATUS_PD_BIT] = 1'b0;
    end

    // Wake from sleep: no register reset, counter moves on
    if (wdt_wake) begin
      cause_d = rcl_pkg::CAUSE_WDT_WAKE;
      sleeping_d = 1'b0;
      pc_d = pc_q + 13'h0001;
      status_d[rcl_pkg::STATUS_TO_BIT] = 1'b0;
      status_d[rcl_pkg::STATUS_PD_BIT] = 1'b0;
    end else if (irq_wake) begin
      sleeping_d = 1'b0;
      pc_d = pc_q + 13'h0001;
      vec_pend_d = irq_ctrl_q[rcl_pkg::GIE_BIT];
      // Only the waking bits change; the rest stays as it was
      pir_d = pir_d | wake_irq_flags;
      status_d[rcl_pkg::STATUS_TO_BIT] = 1'b1;
      status_d[rcl_pkg::STATUS_PD_BIT] = 1'b0;
      cause_d = rcl_pkg::CAUSE_IRQ_WAKE;
    end

    // Cause and flags are taken once, on entry into reset
    if (entry) begin
      if (power_on_detect) begin
        cause_d = rcl_pkg::CAUSE_POWER_ON;
      end else if (supply_dip_detect) begin
        cause_d = rcl_pkg::CAUSE_SUPPLY_DIP;
      end else if (pin_hit) begin
        cause_d = sleeping_q ? rcl_pkg::CAUSE_PIN_SLEEP
                             : rcl_pkg::CAUSE_PIN_RUN;
      end else begin
        cause_d = rcl_pkg::CAUSE_WDT_RUN;
      end
      case (cause_d)
        rcl_pkg::CAUSE_POWER_ON: begin
          status_d = rcl_pkg::STATUS_RST;
          pwr_d = rcl_pkg::PWR_RST;
        end
        rcl_pkg::CAUSE_SUPPLY_DIP: begin
          status_d[rcl_pkg::STATUS_TO_BIT] = 1'b1;
          status_d[rcl_pkg::STATUS_PD_BIT] = 1'b1;
          pwr_d[rcl_pkg::PWR_EN_BIT] = 1'b1;
          pwr_d[rcl_pkg::PWR_DIP_BIT] = 1'b0;
        end
        rcl_pkg::CAUSE_PIN_SLEEP: begin
          status_d[rcl_pkg::STATUS_TO_BIT] = 1'b1;
          status_d[rcl_pkg::STATUS_PD_BIT] = 1'b0;
        end
        rcl_pkg::CAUSE_WDT_RUN: begin
          // Power-down flag keeps its value
          status_d[rcl_pkg::STATUS_TO_BIT] = 1'b0;
        end
        default: begin
          // Pin clear while running leaves both flags alone
          status_d = status_d;
        end
      endcase
      // Hardware set wins over a same-cycle clear or write
      if (nv_write_busy && cause_d != rcl_pkg::CAUSE_POWER_ON) begin
        abort_d = 1'b1;
      end
    end

    // Held reset: PC and most registers at reset values; status bits 4:0, PWR, abort and port latch untouched
    if (any_src) begin
      status_d[7:5] = 3'b000;
      irq_ctrl_d = rcl_pkg::IRQ_CTRL_RST;
      pir_d = rcl_pkg::PIR_RST;
      analog_d = rcl_pkg::ANALOG_RST;
      nv_data_d = rcl_pkg::NV_RST;
      nv_addr_d = rcl_pkg::NV_RST;
      pc_d = rcl_pkg::PC_RST;
      sleeping_d = 1'b0;
      vec_pend_d = 1'b0;
      port_d = port_q;
    end

    // Read data, one cycle after the strobe
    rdata_d = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        rcl_pkg::ADDR_STATUS: rdata_d = status_q;
        rcl_pkg::ADDR_PORT: rdata_d = port_q & ~analog_q;
        rcl_pkg::ADDR_IRQ_CTRL: rdata_d = irq_ctrl_q;
        rcl_pkg::ADDR_PIR: rdata_d = pir_q;
        rcl_pkg::ADDR_PWR: rdata_d = {5'h00, pwr_q};
        rcl_pkg::ADDR_ANALOG: rdata_d = analog_q;
        rcl_pkg::ADDR_NV_DATA: rdata_d = nv_data_q;
        rcl_pkg::ADDR_NV_ADDR: rdata_d = nv_addr_q;
        rcl_pkg::ADDR_NV_CTRL: rdata_d = {4'h0, abort_q, 3'b000};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Power-on reset acts at once; release of core_reset waits for a clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_cnt_q <= 8'h00;
      rst_q <= 1'b1;
      sleeping_q <= 1'b0;
      vec_pend_q <= 1'b0;
      wake_q <= 1'b0;
      pc_q <= rcl_pkg::PC_RST;
      cause_q <= rcl_pkg::CAUSE_POWER_ON;
      status_q <= rcl_pkg::STATUS_RST;
      pwr_q <= rcl_pkg::PWR_RST;
      irq_ctrl_q <= rcl_pkg::IRQ_CTRL_RST;
      pir_q <= rcl_pkg::PIR_RST;
      analog_q <= rcl_pkg::ANALOG_RST;
      nv_data_q <= rcl_pkg::NV_RST;
      nv_addr_q <= rcl_pkg::NV_RST;
      abort_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      filt_cnt_q <= filt_cnt_d;
      rst_q <= rst_d;
      sleeping_q <= sleeping_d;
      vec_pend_q <= vec_pend_d;
      wake_q <= wake_d;
      pc_q <= pc_d;
      cause_q <= cause_d;
      status_q <= status_d;
      pwr_q <= pwr_d;
      irq_ctrl_q <= irq_ctrl_d;
      pir_q <= pir_d;
      analog_q <= analog_d;
      nv_data_q <= nv_data_d;
      nv_addr_q <= nv_addr_d;
      abort_q <= abort_d;
      rdata_q <= rdata_d;
    end
  end

  // No reset at all: content is unknown until software writes it
  always_ff @(posedge clk) begin
    port_q <= port_d;
  end

  assign reg_rdata = rdata_q;
  assign core_reset = rst_q;
  assign program_counter = pc_q;
  assign sleeping = sleeping_q;
  assign wake_pulse = wake_q;
  assign last_cause = cause_q;
  assign irq_control_reg = irq_ctrl_q;
  assign port_latch = port_q;
  assign nv_data_reg = nv_data_q;
  assign nv_addr_reg = nv_addr_q;

endmodule

// *** dv/rcl_reset_asserts.sv ***
// Port checker of the reset cause and init logic
`timescale 1ns/100ps
module rcl_reset_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sources
  input wire logic external_clear_pin_b,
  input wire logic watchdog_timer_expired,
  input wire logic power_on_detect,
  input wire logic supply_dip_detect,
  // Core state
  input wire logic core_reset,
  input wire logic [12:0] program_counter,
  input wire logic sleeping,
  input wire logic wake_pulse,
  input wire rcl_pkg::rcl_cause_type last_cause,
  input wire logic [7:0] irq_control_reg,
  input wire logic [7:0] nv_data_reg,
  input wire logic [7:0] nv_addr_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  dip_reset_a: assert property (supply_dip_detect |=> core_reset)
    else $error("supply dip did not raise core reset");
  // Sampled rst_b keeps the release edge itself out of the antecedent
  core_release_a: assert property (rst_b && core_reset &&
    !supply_dip_detect && !power_on_detect && !watchdog_timer_expired &&
    external_clear_pin_b |=> !core_reset)
    else $error("core reset not released");
  dip_cause_a: assert property (supply_dip_detect &&
    !power_on_detect && !core_reset |=>
    last_cause == rcl_pkg::CAUSE_SUPPLY_DIP)
    else $error("supply dip cause not recorded");
  pc_zero_a: assert property ($rose(core_reset) |->
    program_counter == 13'h0000) else $error("pc not zero on reset");
  // Only a clean wake is checked; a pending pin count would muddle it
  wdt_wake_a: assert property (sleeping && watchdog_timer_expired &&
    !core_reset && external_clear_pin_b && !supply_dip_detect &&
    !power_on_detect |=> wake_pulse && !core_reset)
    else $error("watchdog in sleep did not wake");
  wake_pc_a: assert property (wake_pulse |->
    program_counter == $past(program_counter) + 13'h0001)
    else $error("pc did not advance on wake");
  irq_keep_a: assert property (wake_pulse |->
    irq_control_reg == $past(irq_control_reg))
    else $error("irq control changed on wake");
  nv_clear_a: assert property ($rose(core_reset) |->
    nv_data_reg == 8'h00 && nv_addr_reg == 8'h00)
    else $error("nv holding registers not cleared");

  cover property (wake_pulse && last_cause == rcl_pkg::CAUSE_WDT_WAKE);
  cover property (wake_pulse && last_cause == rcl_pkg::CAUSE_IRQ_WAKE);
  cover property ($fell(core_reset) &&
    last_cause == rcl_pkg::CAUSE_PIN_SLEEP);
endmodule

bind rcl_reset_logic rcl_reset_asserts rcl_reset_asserts_inst (.clk,
  .rst_b, .external_clear_pin_b, .watchdog_timer_expired, .power_on_detect,
  .supply_dip_detect, .core_reset, .program_counter, .sleeping, .wake_pulse,
  .last_cause, .irq_control_reg, .nv_data_reg, .nv_addr_reg);

// *** dv/rcl_source_model.sv ***
// Behavioural model of the reset and wake sources
`timescale 1ns/100ps
module rcl_source_model (
  // Clock
  input wire logic clk,
  // Sources
  output logic external_clear_pin_b,
  output logic watchdog_timer_expired,
  output logic power_on_detect,
  output logic supply_dip_detect
);
  initial begin
    external_clear_pin_b = 1'b1;
    watchdog_timer_expired = 1'b0;
    power_on_detect = 1'b0;
    supply_dip_detect = 1'b0;
  end
  // Assert one source for n edges; the task then drives the pin back high and the rest low
  task drive(input int src, input int n);
    @(posedge clk);
    case (src)
      0: external_clear_pin_b <= 1'b0;
      1: watchdog_timer_expired <= 1'b1;
      2: power_on_detect <= 1'b1;
      default: supply_dip_detect <= 1'b1;
    endcase
    repeat (n) @(posedge clk);
    {external_clear_pin_b, watchdog_timer_expired, power_on_detect,
      supply_dip_detect} <= 4'h8;
  endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench of the reset cause and init logic
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_b, sleep_enter, instr_step, busy, done;
  logic crst, slp, wk, pin_b, wdt, por, dip;
  logic [7:0] irqf, rdata, irq_ctrl, latch, nvd, nva;
  logic [12:0] pc;
  rcl_pkg::rcl_req_type req;
  rcl_pkg::rcl_cause_type cause;
  int bad_count, tests_run, cyc;

  rcl_source_model rcl_source_model_inst (.clk, .external_clear_pin_b(pin_b),
    .watchdog_timer_expired(wdt), .power_on_detect(por),
    .supply_dip_detect(dip));
  rcl_reset_logic rcl_reset_logic_inst (.clk, .rst_b,
    .external_clear_pin_b(pin_b), .watchdog_timer_expired(wdt),
    .power_on_detect(por), .supply_dip_detect(dip), .wake_irq_flags(irqf),
    .sleep_enter, .instr_step, .nv_write_busy(busy), .nv_write_done(done),
    .reg_req(req), .reg_rdata(rdata), .core_reset(crst),
    .program_counter(pc), .sleeping(slp), .wake_pulse(wk),
    .last_cause(cause), .irq_control_reg(irq_ctrl), .port_latch(latch),
    .nv_data_reg(nvd), .nv_addr_reg(nva));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 check(13'(rdata), 13'(e));
  endtask
  task strobe(input logic [1:0] v);
    @(posedge clk);
    {sleep_enter, instr_step} <= v;
    @(posedge clk);
    {sleep_enter, instr_step} <= 2'b00;
  endtask
  task wait_rst(input logic lvl);
    int n;
    n = 0;
    #1;
    while (crst !== lvl && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    check(13'(crst), 13'(lvl));
  endtask
  task cause_is(input rcl_pkg::rcl_cause_type c);
    check(13'(cause), 13'(c));
  endtask

  initial begin
    rst_b = 1'b0;
    req = '0;
    irqf = 8'h00;
    {sleep_enter, instr_step, busy, done} = 4'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    wait_rst(1'b0);
    rd(rcl_pkg::ADDR_STATUS, 8'h18);
    rd(rcl_pkg::ADDR_PWR, 8'h04);
    rd(9'h1FF, 8'h00);
    wr(rcl_pkg::ADDR_PORT, 8'hA5);
    wr(rcl_pkg::ADDR_ANALOG, 8'h0F);
    rd(rcl_pkg::ADDR_PORT, 8'hA0);
    wr(rcl_pkg::ADDR_NV_DATA, 8'h5A);
    wr(rcl_pkg::ADDR_NV_ADDR, 8'h3C);
    strobe(2'b10);
    #1 check(13'(slp), 13'h0001);
    rd(rcl_pkg::ADDR_STATUS, 8'h10);
    rcl_source_model_inst.drive(1, 1);
    #1 check(pc, 13'h0001);
    cause_is(rcl_pkg::CAUSE_WDT_WAKE);
    check(13'(wk), 13'h0001);
    check(13'(slp), 13'h0000);
    rd(rcl_pkg::ADDR_STATUS, 8'h00);
    rd(rcl_pkg::ADDR_NV_DATA, 8'h5A);
    rd(rcl_pkg::ADDR_NV_ADDR, 8'h3C);
    // Upper bits must clear on reset, low bits must survive it
    wr(rcl_pkg::ADDR_STATUS, 8'hE5);
    // Watchdog while running, in mid nonvolatile write
    busy <= 1'b1;
    rcl_source_model_inst.drive(1, 1);
    wait_rst(1'b1);
    busy <= 1'b0;
    wait_rst(1'b0);
    cause_is(rcl_pkg::CAUSE_WDT_RUN);
    check(13'(latch), 13'h00A5);
    check(13'(nvd), 13'h0000);
    check(13'(nva), 13'h0000);
    rd(rcl_pkg::ADDR_PORT, 8'h00);
    rd(rcl_pkg::ADDR_STATUS, 8'h05);
    rd(rcl_pkg::ADDR_NV_DATA, 8'h00);
    rd(rcl_pkg::ADDR_NV_CTRL, 8'h08);
    strobe(2'b00);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rd(rcl_pkg::ADDR_NV_CTRL, 8'h00);
    // Pin glitch just short of the filter, then a long hold
    rcl_source_model_inst.drive(0, int'(rcl_pkg::EXT_CLEAR_CYC) - 2);
    repeat (2) @(posedge clk);
    #1 check(13'(crst), 13'h0000);
    rcl_source_model_inst.drive(0, int'(rcl_pkg::EXT_CLEAR_CYC) + 5);
    wait_rst(1'b0);
    cause_is(rcl_pkg::CAUSE_PIN_RUN);
    rd(rcl_pkg::ADDR_STATUS, 8'h05);
    strobe(2'b10);
    rcl_source_model_inst.drive(0, int'(rcl_pkg::EXT_CLEAR_CYC) + 5);
    wait_rst(1'b0);
    cause_is(rcl_pkg::CAUSE_PIN_SLEEP);
    rd(rcl_pkg::ADDR_STATUS, 8'h15);
    // Interrupt wake with the global enable set
    wr(rcl_pkg::ADDR_IRQ_CTRL, 8'h80);
    strobe(2'b10);
    irqf <= 8'h02;
    @(posedge clk);
    irqf <= 8'h00;
    #1 check(pc, 13'h0001);
    cause_is(rcl_pkg::CAUSE_IRQ_WAKE);
    check(13'(irq_ctrl), 13'h0080);
    rd(rcl_pkg::ADDR_PIR, 8'h02);
    rd(rcl_pkg::ADDR_STATUS, 8'h15);
    strobe(2'b01);
    #1 check(pc, 13'h0004);
    // Supply dip then power-on detector
    wr(rcl_pkg::ADDR_PWR, 8'h07);
    rcl_source_model_inst.drive(3, 4);
    wait_rst(1'b0);
    cause_is(rcl_pkg::CAUSE_SUPPLY_DIP);
    rd(rcl_pkg::ADDR_PWR, 8'h06);
    rd(rcl_pkg::ADDR_STATUS, 8'h1D);
    rcl_source_model_inst.drive(2, 4);
    wait_rst(1'b0);
    cause_is(rcl_pkg::CAUSE_POWER_ON);
    rd(rcl_pkg::ADDR_PWR, 8'h04);
    rd(rcl_pkg::ADDR_STATUS, 8'h18);
    finish_test();
  end
endmodule
